//--- hw/lsm_monitor.sv
// lsm_monitor: limited-speed supervision of one drive axis.
// assumes requests and encoder data are same-clock logic on clk;
// the register port is a plain strobe port, read data one cycle later.
//
// Overview of operation
// - four request inputs, any combination allowed
// - several requests: smallest limit is enforced
// - enabled with a request active and bad encoder: fail at once
// - over the enforced limit: latched fail until ack
// - fail state drops the torque enable output
// - fail state clears the no-error output
// - zero monitoring time: enforce next cycle
// - status bit while limit safely enforced
// - ramp or time-only mode, ramp default
// - configurable ramp slope, units per second squared
// - timer starts when a request becomes active
// - ramp check starts after the start delay
// - ramp starts at enforced limit, falls by slope
// - ramp at target or timeout: enforce target
// - per-limit monitoring time in microseconds, default zero
// - early completion after speed stays below target
// - four limit values in units per second
// - start delay in microseconds, default zero
// - time-only: enforce after delay plus monitoring time
`timescale 1ns/1ps
module lsm_monitor
	import lsm_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// register port
	input  wire logic [AW-1:0]         reg_addr,
	input  wire logic [DW-1:0]         reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [DW-1:0]              reg_rdata,
	// safe application requests
	input  wire logic [NUM_LIMITS-1:0] speed_limit_request,
	// safe encoder feedback
	input  wire lsm_enc_t              enc,
	// drive outputs
	output lsm_drive_t                 drive
);

	// magnitude of a signed speed
	function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
		return v[DW-1] ? DW'(-v) : DW'(v);
	endfunction

	// speed scaled by the clock rate, so per-cycle slope steps are exact
	function automatic logic [63:0] scale_hz(input logic [DW-1:0] v);
		return {32'h0000_0000, v} * 64'(CLK_HZ);
	endfunction

	// index of the smallest requested limit
	function automatic logic [1:0] min_idx(
		input logic [NUM_LIMITS-1:0] rq,
		input logic [DW-1:0]         lim [NUM_LIMITS]
	);
		logic [1:0]    best;
		logic [DW-1:0] bv;
		logic          hit;
		best = 2'd0;
		bv   = NO_LIMIT;
		hit  = 1'b0;
		for (int i = 0; i < NUM_LIMITS; i++) begin
			if (rq[i] && (!hit || lim[i] < bv)) begin
				best = 2'(i);
				bv   = lim[i];
				hit  = 1'b1;
			end
		end
		return best;
	endfunction

	// ---------------- register file ----------------
	logic [DW-1:0] ctrl_reg,    ctrl_next;     // enable, mode, early
	logic [DW-1:0] slope_reg,   slope_next;    // ramp slope
	logic [DW-1:0] delay_reg,   delay_next;    // ramp start delay, us
	logic [DW-1:0] early_reg,   early_next;    // early completion time, us
	logic [DW-1:0] lim_reg  [NUM_LIMITS];      // speed_limit_value
	logic [DW-1:0] lim_next [NUM_LIMITS];
	logic [DW-1:0] tmon_reg [NUM_LIMITS];      // decel_monitor_time
	logic [DW-1:0] tmon_next[NUM_LIMITS];
	logic [DW-1:0] rdata_reg,   rdata_next;    // read data, one cycle late
	logic          ack;                        // fault acknowledge pulse

	// supervision state (declared here, read back by software)
	lsm_state_t    state_reg,   state_next;
	logic [DW-1:0] enf_reg,     enf_next;      // limit enforced now
	lsm_drive_t    drive_reg,   drive_next;

	// register writes and read mux
	always_comb begin
		ctrl_next  = ctrl_reg;
		slope_next = slope_reg;
		delay_next = delay_reg;
		early_next = early_reg;
		lim_next   = lim_reg;
		tmon_next  = tmon_reg;
		rdata_next = '0;
		ack        = 1'b0;
		if (reg_wr) begin
			if (reg_addr == OFS_CTRL) begin
				ctrl_next = {29'h0000_0000, reg_wdata[2:0]};
				ack       = reg_wdata[CTRL_ACK];
			end else if (reg_addr == OFS_SLOPE) begin
				slope_next = reg_wdata;
			end else if (reg_addr == OFS_DELAY) begin
				delay_next = reg_wdata;
			end else if (reg_addr == OFS_EARLY_T) begin
				early_next = reg_wdata;
			end else if (reg_addr[7:4] == OFS_LIMIT0[7:4]) begin
				lim_next[reg_addr[3:2]] = reg_wdata;
			end else if (reg_addr[7:4] == OFS_TMON0[7:4]) begin
				tmon_next[reg_addr[3:2]] = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (reg_addr == OFS_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (reg_addr == OFS_STATUS) begin
				rdata_next[STAT_LIMIT]  = drive_reg.limit_status;
				rdata_next[STAT_NOERR]  = drive_reg.no_function_error_out;
				rdata_next[STAT_TORQUE] = drive_reg.torque_enable;
				rdata_next[STAT_STATE +: 3] = state_reg;
			end else if (reg_addr == OFS_SLOPE) begin
				rdata_next = slope_reg;
			end else if (reg_addr == OFS_DELAY) begin
				rdata_next = delay_reg;
			end else if (reg_addr == OFS_EARLY_T) begin
				rdata_next = early_reg;
			end else if (reg_addr == OFS_ENFORCED) begin
				rdata_next = enf_reg;
			end else if (reg_addr[7:4] == OFS_LIMIT0[7:4]) begin
				rdata_next = lim_reg[reg_addr[3:2]];
			end else if (reg_addr[7:4] == OFS_TMON0[7:4]) begin
				rdata_next = tmon_reg[reg_addr[3:2]];
			end
		end
	end

	// register file flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg  <= RST_CTRL;
			slope_reg <= RST_SLOPE;
			delay_reg <= RST_DELAY;
			early_reg <= RST_EARLY;
			rdata_reg <= '0;
			for (int i = 0; i < NUM_LIMITS; i++) begin
				lim_reg[i]  <= RST_LIMIT;
				tmon_reg[i] <= RST_TMON;
			end
		end else begin
			ctrl_reg  <= ctrl_next;
			slope_reg <= slope_next;
			delay_reg <= delay_next;
			early_reg <= early_next;
			rdata_reg <= rdata_next;
			lim_reg   <= lim_next;
			tmon_reg  <= tmon_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ---------------- supervision ----------------
	logic [NUM_LIMITS-1:0] req_prev_reg;   // requests one cycle ago
	logic [63:0]   ramp_reg, ramp_next;    // ramp value times CLK_HZ
	logic          enable;                 // function enabled
	logic          ramp_mode;              // ramp plus time, else time
	logic          early_en;               // early completion on
	logic          any_req;                // at least one request
	logic          req_chg;                // request set changed
	logic          bad_enc;                // no encoder or faulty
	logic [1:0]    tidx;                   // index of target limit
	logic [DW-1:0] target;                 // smallest requested limit
	logic [DW-1:0] ttmon;                  // its monitoring time
	logic [DW-1:0] spd;                    // speed magnitude
	logic [63:0]   spd_hz;                 // speed magnitude scaled
	logic          run_req;                // request timer runs
	logic          run_early;              // early timer runs
	logic [DW-1:0] req_us;                 // us since request
	logic [DW-1:0] early_us;               // us below target

	assign enable    = ctrl_reg[CTRL_ENABLE];
	assign ramp_mode = ctrl_reg[CTRL_RAMP];
	assign early_en  = ctrl_reg[CTRL_EARLY];
	assign any_req   = |speed_limit_request;
	assign req_chg   = speed_limit_request != req_prev_reg;
	assign bad_enc   = !enc.present || enc.fault;
	assign tidx      = min_idx(speed_limit_request, lim_reg);
	assign target    = lim_reg[tidx];
	assign ttmon     = tmon_reg[tidx];
	assign spd       = mag(enc.speed);
	assign spd_hz    = scale_hz(spd);

	// the request timer restarts whenever the request set changes
	assign run_req   = (state_reg == ST_DELAY || state_reg == ST_RAMP)
	                   && !req_chg;
	assign run_early = state_reg == ST_RAMP && early_en
	                   && spd < target;

	// time since the request became active
	lsm_elapsed_us #(
		.W (DW)
	) u_req_timer (
		.clk        (clk),
		.resetn     (resetn),
		.run        (run_req),
		.elapsed_us (req_us)
	);

	// time the speed has stayed below the target
	lsm_elapsed_us #(
		.W (DW)
	) u_early_timer (
		.clk        (clk),
		.resetn     (resetn),
		.run        (run_early),
		.elapsed_us (early_us)
	);

	// next state, enforced limit and ramp
	always_comb begin
		state_next = state_reg;
		enf_next   = enf_reg;
		ramp_next  = ramp_reg;
		case (state_reg)
			ST_IDLE: begin
				enf_next  = NO_LIMIT;
				ramp_next = '0;
				if (enable && any_req) begin
					if (bad_enc) begin
						state_next = ST_FAIL;
					end else if (ttmon == '0) begin
						state_next = ST_SAFE;
						enf_next   = target;
					end else begin
						state_next = ST_DELAY;
						ramp_next  = scale_hz(enf_reg);
					end
				end
			end
			ST_DELAY, ST_RAMP, ST_SAFE: begin
				if (!enable || !any_req) begin
					state_next = ST_IDLE;
					enf_next   = NO_LIMIT;
					ramp_next  = '0;
				end else if (bad_enc) begin
					state_next = ST_FAIL;
				end else if (spd > enf_reg) begin
					state_next = ST_FAIL;
				end else if (req_chg) begin
					// new request set: restart from the limit held now
					if (ttmon == '0) begin
						state_next = ST_SAFE;
						enf_next   = target;
					end else begin
						state_next = ST_DELAY;
						ramp_next  = scale_hz(enf_reg);
					end
				end else if (state_reg == ST_DELAY) begin
					if (ramp_mode) begin
						if (req_us >= ttmon) begin
							state_next = ST_SAFE;
							enf_next   = target;
						end else if (req_us >= delay_reg) begin
							state_next = ST_RAMP;
						end
					end else if ({1'b0, req_us} >=
					             {1'b0, delay_reg} + {1'b0, ttmon}) begin
						state_next = ST_SAFE;
						enf_next   = target;
					end
				end else if (state_reg == ST_RAMP) begin
					if (spd_hz > ramp_reg) begin
						state_next = ST_FAIL;
					end else if (ramp_reg <= scale_hz(target)
					             || req_us >= ttmon) begin
						state_next = ST_SAFE;
						enf_next   = target;
					end else if (run_early && early_us >= early_reg) begin
						state_next = ST_SAFE;
						enf_next   = target;
					end else if (ramp_reg > {32'h0000_0000, slope_reg}) begin
						ramp_next = ramp_reg - {32'h0000_0000, slope_reg};
					end else begin
						ramp_next = '0;
					end
				end else begin
					enf_next = target;
				end
			end
			ST_FAIL: begin
				// latched until software acknowledges
				if (ack) begin
					state_next = ST_IDLE;
					enf_next   = NO_LIMIT;
					ramp_next  = '0;
				end
			end
			default: begin
				state_next = ST_FAIL;
				enf_next   = NO_LIMIT;
				ramp_next  = '0;
			end
		endcase
	end

	// drive outputs follow the state being entered
	always_comb begin
		drive_next.torque_enable         = state_next != ST_FAIL;
		drive_next.no_function_error_out = state_next != ST_FAIL;
		drive_next.limit_status          = state_next == ST_SAFE;
	end

	// supervision flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= ST_IDLE;
			enf_reg      <= NO_LIMIT;
			ramp_reg     <= '0;
			req_prev_reg <= '0;
			drive_reg    <= '{torque_enable: 1'b1,
			                  no_function_error_out: 1'b1,
			                  limit_status: 1'b0};
		end else begin
			state_reg    <= state_next;
			enf_reg      <= enf_next;
			ramp_reg     <= ramp_next;
			req_prev_reg <= speed_limit_request;
			drive_reg    <= drive_next;
		end
	end

	assign drive = drive_reg;

endmodule

//--- hw/lsm_pkg.sv
// lsm_pkg: shared constants, state encoding and carriers for the
// limited-speed monitor.
// assumes a single 25 MHz clock and a plain register port of 8/32 bits.
package lsm_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned US_PER_S   = 1_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;

	// sizes
	localparam int NUM_LIMITS = 4;
	localparam int DW         = 32;
	localparam int AW         = 8;

	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
	localparam logic [AW-1:0] OFS_STATUS   = 8'h04;
	localparam logic [AW-1:0] OFS_SLOPE    = 8'h08;
	localparam logic [AW-1:0] OFS_DELAY    = 8'h0C;
	localparam logic [AW-1:0] OFS_EARLY_T  = 8'h10;
	localparam logic [AW-1:0] OFS_ENFORCED = 8'h14;
	localparam logic [AW-1:0] OFS_LIMIT0   = 8'h20;
	localparam logic [AW-1:0] OFS_TMON0    = 8'h30;

	// control register bit positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_RAMP   = 1;
	localparam int CTRL_EARLY  = 2;
	localparam int CTRL_ACK    = 3;

	// status register bit positions
	localparam int STAT_LIMIT  = 0;
	localparam int STAT_NOERR  = 1;
	localparam int STAT_TORQUE = 2;
	localparam int STAT_STATE  = 4;

	// values after reset
	localparam logic [DW-1:0] RST_CTRL  = 32'h0000_0002;
	localparam logic [DW-1:0] RST_SLOPE = 32'h3FFF_0001;
	localparam logic [DW-1:0] RST_LIMIT = 32'h0000_0000;
	localparam logic [DW-1:0] RST_TMON  = 32'h0000_0000;
	localparam logic [DW-1:0] RST_DELAY = 32'h0000_0000;
	localparam logic [DW-1:0] RST_EARLY = 32'h0000_0000;
	localparam logic [DW-1:0] NO_LIMIT  = 32'hFFFF_FFFF;

	// supervision states, gray along idle-delay-ramp-safe-fail
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DELAY = 3'b001,
		ST_RAMP  = 3'b011,
		ST_SAFE  = 3'b010,
		ST_FAIL  = 3'b110
	} lsm_state_t;

	// speed feedback from the safe encoder
	typedef struct packed {
		logic                 present;
		logic                 fault;
		logic signed [DW-1:0] speed;
	} lsm_enc_t;

	// drive-side outputs
	typedef struct packed {
		logic torque_enable;
		logic no_function_error_out;
		logic limit_status;
	} lsm_drive_t;

endpackage

//--- hw/lsm_elapsed_us.sv
// lsm_elapsed_us: microsecond elapsed-time counter with prescaler.
// assumes run is a same-clock level; low clears the count at once.
`timescale 1ns/1ps
module lsm_elapsed_us
	import lsm_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// control
	input  wire logic         run,
	// whole microseconds since run rose, saturating
	output logic [W-1:0]      elapsed_us
);

	localparam int PW = $clog2(CYC_PER_US + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_US - 1);

	logic [PW-1:0] pre_reg;   // cycles within current microsecond
	logic [PW-1:0] pre_next;
	logic [W-1:0]  cnt_reg;   // microseconds elapsed
	logic [W-1:0]  cnt_next;

	// next prescaler and count
	always_comb begin
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		if (!run) begin
			pre_next = '0;
			cnt_next = '0;
		end else if (pre_reg == PRE_LAST) begin
			pre_next = '0;
			if (cnt_reg != '1) begin
				cnt_next = cnt_reg + 1'b1;
			end
		end else begin
			pre_next = pre_reg + 1'b1;
		end
	end

	// register the counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pre_reg <= '0;
			cnt_reg <= '0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	assign elapsed_us = cnt_reg;

endmodule

//--- verification/lsm_monitor_properties.sv
// lsm_checker: port-level properties of the limited-speed monitor.
// assumes it is bound to lsm_monitor and sees only its ports.
`timescale 1ns/1ps
module lsm_checker
	import lsm_pkg::*;
(
	// clock and reset
	input wire logic                  clk,
	input wire logic                  resetn,
	// register port
	input wire logic [AW-1:0]         reg_addr,
	input wire logic [DW-1:0]         reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [DW-1:0]         reg_rdata,
	// axis side
	input wire logic [NUM_LIMITS-1:0] speed_limit_request,
	input wire lsm_enc_t              enc,
	input wire lsm_drive_t            drive
);
	logic en_reg;  // shadow of the enable bit
	logic en_next; // its next value
	logic ctrl_wr; // write to control
	logic ack_wr;  // acknowledge write
	logic enc_bad; // encoder missing or faulty
	assign ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
	assign ack_wr  = ctrl_wr && reg_wdata[CTRL_ACK];
	assign enc_bad = !enc.present || enc.fault;
	// shadow follows every control write
	always_comb begin
		en_next = ctrl_wr ? reg_wdata[CTRL_ENABLE] : en_reg;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			en_reg <= 1'b0;
		else
			en_reg <= en_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// fail state seen at the drive outputs
	sequence s_failed;
		!drive.no_function_error_out;
	endsequence
	// idle outputs after release
	sequence s_released;
		drive.no_function_error_out && drive.torque_enable
			&& !drive.limit_status;
	endsequence
	property p_fail_torque;
		s_failed |-> !drive.torque_enable;
	endproperty
	a_fail_torque: assert property (p_fail_torque)
		else $error("torque on in fail state");
	property p_fall_pair;
		$fell(drive.no_function_error_out) |-> $fell(drive.torque_enable);
	endproperty
	a_fall_pair: assert property (p_fall_pair)
		else $error("no-error and torque did not drop together");
	property p_fail_status;
		s_failed |-> !drive.limit_status;
	endproperty
	a_fail_status: assert property (p_fail_status)
		else $error("status set in fail state");
	property p_bad_enc;
		en_reg && |speed_limit_request && enc_bad && !reg_wr |=> s_failed;
	endproperty
	a_bad_enc: assert property (p_bad_enc)
		else $error("bad encoder not failed");
	property p_latched;
		s_failed ##0 !ctrl_wr |=> s_failed;
	endproperty
	a_latched: assert property (p_latched)
		else $error("fail left without acknowledge");
	property p_ack;
		s_failed ##0 ack_wr |=> s_released;
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge did not release");
	property p_withdraw;
		drive.no_function_error_out && speed_limit_request == '0
			|=> !drive.limit_status;
	endproperty
	a_withdraw: assert property (p_withdraw)
		else $error("status kept without request");
	property p_disabled;
		!en_reg |=> !drive.limit_status;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("status set while disabled");
	property p_rise_cause;
		$rose(drive.limit_status) |-> $past(|speed_limit_request);
	endproperty
	a_rise_cause: assert property (p_rise_cause)
		else $error("status rose without request");
endmodule

bind lsm_monitor lsm_checker u_chk (
	.clk                 (clk),
	.resetn              (resetn),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_wr              (reg_wr),
	.reg_rd              (reg_rd),
	.reg_rdata           (reg_rdata),
	.speed_limit_request (speed_limit_request),
	.enc                 (enc),
	.drive               (drive)
);

//--- verification/lsm_axis.sv
// lsm_axis: safe application and encoder model on the far side.
// assumes commands come from the bench; all outputs are registered.
`timescale 1ns/1ps
module lsm_axis
	import lsm_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// commands from the bench
	input  wire logic [NUM_LIMITS-1:0] req_cmd,
	input  wire logic [DW-1:0]         speed_cmd,
	input  wire logic                  present_cmd,
	input  wire logic                  fault_cmd,
	// toward the monitor
	output logic [NUM_LIMITS-1:0]      speed_limit_request,
	output lsm_enc_t                   enc
);
	// registered levels, as the real sources change on the clock;
	// the application holds commanded speed, only overspeed tests exceed
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			speed_limit_request <= '0;
			enc                 <= '{1'b1, 1'b0, 32'sh0000_0000};
		end else begin
			speed_limit_request <= req_cmd;
			enc.present         <= present_cmd;
			enc.fault           <= fault_cmd;
			enc.speed           <= signed'(speed_cmd);
		end
	end
endmodule

//--- verification/lsm_monitor_tb.sv
// lsm_monitor_tb: directed scenarios for the limited-speed monitor.
// assumes the axis model feeds requests and encoder data.
`timescale 1ns/1ps
module lsm_monitor_tb
	import lsm_pkg::*;
;
	logic                  clk;
	logic                  resetn;
	logic [AW-1:0]         reg_addr;
	logic [DW-1:0]         reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [DW-1:0]         reg_rdata;
	logic [NUM_LIMITS-1:0] req_cmd;     // requests to the model
	logic [DW-1:0]         speed_cmd;   // speed to the model
	logic                  present_cmd;
	logic                  fault_cmd;
	logic [NUM_LIMITS-1:0] speed_limit_request;
	lsm_enc_t              enc;
	lsm_drive_t            drive;
	int                    errors;
	int                    checks_done;
	logic [DW-1:0]         lim [NUM_LIMITS]; // limit table

	always #20 clk = ~clk;

	lsm_monitor DUT (
		.clk                 (clk),
		.resetn              (resetn),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.speed_limit_request (speed_limit_request),
		.enc                 (enc),
		.drive               (drive)
	);

	lsm_axis u_axis (
		.clk                 (clk),
		.resetn              (resetn),
		.req_cmd             (req_cmd),
		.speed_cmd           (speed_cmd),
		.present_cmd         (present_cmd),
		.fault_cmd           (fault_cmd),
		.speed_limit_request (speed_limit_request),
		.enc                 (enc)
	);

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one comparison of a word
	task automatic chk(input string n, input logic [DW-1:0] e,
		input logic [DW-1:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read and compare; data stands in the cycle after the strobe
	task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask

	// new commands for the axis model
	task automatic axis(input logic [3:0] r, input int s);
		@(posedge clk);
		req_cmd   <= r;
		speed_cmd <= DW'(s);
	endtask

	// bounded wait for one drive bit; a timeout ends the run
	task automatic wait_out(input int b, input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (drive[b] === v)
				break;
		end
		chk($sformatf("drive bit %0d", b), {31'h0, v}, {31'h0, drive[b]});
		if (drive[b] !== v)
			final_report();
	endtask

	// settled look at the outputs after n edges
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		rdchk(OFS_CTRL, RST_CTRL);
		rdchk(OFS_SLOPE, RST_SLOPE);
		rdchk(OFS_LIMIT0, RST_LIMIT);
		rdchk(OFS_TMON0, RST_TMON);
		rdchk(OFS_DELAY, RST_DELAY);
		rdchk(8'hFC, 32'h0000_0000);
		$display("t_reset done");
	endtask

	// every request combination, smallest limit enforced
	task automatic t_multi();
		logic [DW-1:0] m;
		int k;
		int j;
		lim = '{32'h0000_0190, 32'h0000_00C8, 32'h0000_012C, 32'h0000_0096};
		for (j = 0; j < NUM_LIMITS; j++)
			wr(OFS_LIMIT0 + AW'(4 * j), lim[j]);
		wr(OFS_CTRL, 32'h0000_0003);
		for (k = 1; k < 16; k++) begin
			axis(k[3:0], 0);
			cyc(4);
			m = NO_LIMIT;
			for (j = 0; j < NUM_LIMITS; j++)
				if (k[j] && lim[j] < m)
					m = lim[j];
			rdchk(OFS_ENFORCED, m);
			rdchk(OFS_STATUS, 32'h0000_0027);
		end
		axis(4'h0, 0);
		wait_out(0, 1'b0, 5);
		rdchk(OFS_STATUS, 32'h0000_0006);
		$display("t_multi done");
	endtask

	// overspeed in reverse direction, latched until acknowledged
	task automatic t_over();
		axis(4'h1, 0);
		wait_out(0, 1'b1, 5);
		axis(4'h1, -401);
		wait_out(1, 1'b0, 5);
		rdchk(OFS_STATUS, 32'h0000_0060);
		cyc(10);
		rdchk(OFS_STATUS, 32'h0000_0060);
		axis(4'h1, 0);
		wr(OFS_CTRL, 32'h0000_000B);
		wait_out(1, 1'b1, 3);
		wait_out(0, 1'b1, 5);
		$display("t_over done");
	endtask

	// missing encoder, then faulty encoder
	task automatic t_enc();
		int i;
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			present_cmd <= i[0];
			fault_cmd   <= i[0];
			wait_out(1, 1'b0, 5);
			@(posedge clk);
			present_cmd <= 1'b1;
			fault_cmd   <= 1'b0;
			wr(OFS_CTRL, 32'h0000_000B);
			wait_out(1, 1'b1, 3);
		end
		$display("t_enc done");
	endtask

	// time-only mode: delay 1 us plus monitoring 2 us
	task automatic t_time();
		axis(4'h0, 0);
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_DELAY, 32'h0000_0001);
		wr(OFS_TMON0, 32'h0000_0002);
		axis(4'h1, 0);
		cyc(60);
		chk("status early", 32'h0000_0000, {31'h0, drive[0]});
		wait_out(0, 1'b1, 40);
		$display("t_time done");
	endtask

	// ramp overrun after the start delay, then early completion
	task automatic t_ramp();
		axis(4'h0, 0);
		wr(OFS_TMON0, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0003);
		wr(OFS_SLOPE, 32'h017D_7840);
		wr(OFS_DELAY, 32'h0000_0002);
		wr(OFS_TMON0 + 8'h04, 32'h0000_0028);
		axis(4'h1, 390);
		wait_out(0, 1'b1, 5);
		axis(4'h3, 390);
		cyc(40);
		chk("no error", 32'h0000_0001, {31'h0, drive[1]});
		wait_out(1, 1'b0, 60);
		axis(4'h3, 150);
		wr(OFS_EARLY_T, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_000F);
		wait_out(1, 1'b1, 3);
		wait_out(0, 1'b1, 150);
		rdchk(OFS_ENFORCED, 32'h0000_00C8);
		$display("t_ramp done");
	endtask

	initial begin
		clk         = 1'b0;
		resetn      = 1'b0;
		reg_addr    = '0;
		reg_wdata   = '0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		req_cmd     = '0;
		speed_cmd   = '0;
		present_cmd = 1'b1;
		fault_cmd   = 1'b0;
		errors      = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_multi();
		t_over();
		t_enc();
		t_time();
		t_ramp();
		final_report();
	end
endmodule
